// ==== gpib_remote_status_control.sv ====
// Remote/local, device clear, trigger, service request and status word control
`timescale 1ns/1ps
`default_nettype none
module gpib_remote_status_control
  import gpib_rsc_pkg::*;
(
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic ifc_i, // Interface clear pulse
  input wire logic ren_i, // Remote enable message true (line low)
  input wire logic my_listen_addr_i, // Own listen address received, pulse
  input wire logic my_talk_addr_i, // Own talk address received, pulse
  input wire logic unlisten_i, // Unlisten received, pulse
  input wire logic untalk_i, // Untalk received, pulse
  input wire logic dcl_i, // Universal device clear, pulse
  input wire logic sdc_i, // Selective device clear, pulse
  input wire logic gtl_i, // Go to local, pulse
  input wire logic get_i, // Group execute trigger, pulse
  input wire logic srq_enable_wr_i, // Service request enable code decoded
  input wire logic srq_enable_val_i, // Its value
  input wire logic header_wr_i, // Header output code decoded
  input wire logic header_val_i, // Its value
  input wire logic trigger_cmd_i, // Manual trigger code decoded
  input wire logic zero_open_cmd_i, // Open zero correction code decoded
  input wire logic zero_short_cmd_i, // Short zero correction code decoded
  input wire logic condition_query_i, // Status query code decoded
  input wire logic serial_poll_i, // Status word sent in a serial poll, pulse
  input wire logic meas_done_i, // Measurement finished, pulse
  input wire logic zero_done_i, // Zero correction finished, pulse
  input wire logic zero_fail_i, // With zero_done_i: value too large
  input wire logic key_i, // Front panel key press, pulse
  input wire logic key_is_err_reset_i, // That key is error reset
  output logic srq_o, // Service request line asserted
  output logic [STAT_W-1:0] status_byte_o, // Status word
  output logic remote_o, // Remote indicator
  output logic listener_o, // Addressed as listener
  output logic talker_o, // Addressed as talker
  output logic srq_enable_o, // Service request enable setting
  output logic header_enable_o, // Header output setting
  output logic meas_start_o, // Start measurement, pulse
  output logic zero_open_start_o, // Start open correction, pulse
  output logic zero_short_start_o, // Start short correction, pulse
  output logic clear_error_o, // Reset error, pulse
  output logic flush_tx_o, // Empty transmit buffer, pulse
  output logic flush_rx_o, // Empty receive buffer, pulse
  output logic setup_exit_o, // Force setup mode exit, pulse
  output logic key_accept_o, // Panel key passed on, pulse
  output logic bus_codes_enable_o // Program codes executed
);

  ////////////////////////////////////////////////////////////////////////////
  // Addressing
  logic listener, talker, next_listener, next_talker;
  logic dev_clear, status_read;

  always_comb begin
    next_listener = listener;
    next_talker = talker;
    if (my_listen_addr_i) next_listener = 1'b1;
    if (unlisten_i) next_listener = 1'b0;
    if (my_talk_addr_i) begin
      next_talker = 1'b1;
      next_listener = 1'b0;
    end
    if (untalk_i) next_talker = 1'b0;
    if (my_listen_addr_i && !my_talk_addr_i) next_talker = 1'b0;
    if (ifc_i) begin
      next_listener = 1'b0;
      next_talker = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      listener <= 1'b0;
      talker <= 1'b0;
    end else begin
      listener <= next_listener;
      talker <= next_talker;
    end
  end

  assign dev_clear = dcl_i || (sdc_i && listener);
  assign listener_o = listener;
  assign talker_o = talker;

  ////////////////////////////////////////////////////////////////////////////
  // Remote / local
  rl_mode_t mode, next_mode;
  logic is_remote, go_remote;

  assign go_remote = ren_i && my_listen_addr_i;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_LOCAL: begin
        if (go_remote) next_mode = MODE_REMOTE;
      end
      MODE_REMOTE: begin
        if (!ren_i || (gtl_i && listener)) next_mode = MODE_LOCAL;
      end
      default: next_mode = MODE_LOCAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) mode <= MODE_LOCAL;
    else mode <= next_mode;
  end

  assign is_remote = (mode == MODE_REMOTE);
  assign remote_o = is_remote;
  assign bus_codes_enable_o = is_remote;
  assign setup_exit_o = (mode == MODE_LOCAL) && go_remote;
  assign key_accept_o = key_i && (!is_remote || key_is_err_reset_i);

  ////////////////////////////////////////////////////////////////////////////
  // Settings written by program codes
  logic srq_en, hdr_en, next_srq_en, next_hdr_en;

  always_comb begin
    next_srq_en = srq_en;
    next_hdr_en = hdr_en;
    if (is_remote && srq_enable_wr_i) next_srq_en = srq_enable_val_i;
    if (is_remote && header_wr_i) next_hdr_en = header_val_i;
    if (dev_clear) begin
      next_srq_en = CLR_ENABLE_VAL;
      next_hdr_en = CLR_ENABLE_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      srq_en <= RST_SRQ_EN;
      hdr_en <= RST_HDR_EN;
    end else begin
      srq_en <= next_srq_en;
      hdr_en <= next_hdr_en;
    end
  end

  assign srq_enable_o = srq_en;
  assign header_enable_o = hdr_en;
  assign clear_error_o = dev_clear;
  assign flush_tx_o = dev_clear;
  assign flush_rx_o = dev_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement and zero correction tracking
  logic meas_run, zero_run, trig_wait;
  logic next_meas_run, next_zero_run, next_trig_wait;
  logic trig_req, zero_req, busy;

  assign busy = meas_run || zero_run;
  // Bus trigger needs remote and listener; a running job blocks it
  assign trig_req = ((get_i && listener) || trigger_cmd_i) && is_remote && !busy;
  assign zero_req = (zero_open_cmd_i || zero_short_cmd_i) && is_remote && !busy;

  always_comb begin
    next_meas_run = meas_run;
    next_zero_run = zero_run;
    next_trig_wait = trig_wait;
    if (trig_req) begin
      next_meas_run = 1'b1;
      next_trig_wait = 1'b1;
    end
    if (zero_req) next_zero_run = 1'b1;
    if (meas_done_i) next_meas_run = 1'b0;
    if (zero_done_i) next_zero_run = 1'b0;
    if (meas_done_i || dev_clear) next_trig_wait = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meas_run <= 1'b0;
      zero_run <= 1'b0;
      trig_wait <= 1'b0;
    end else begin
      meas_run <= next_meas_run;
      zero_run <= next_zero_run;
      trig_wait <= next_trig_wait;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meas_start_o <= 1'b0;
      zero_open_start_o <= 1'b0;
      zero_short_start_o <= 1'b0;
    end else begin
      meas_start_o <= trig_req;
      zero_open_start_o <= zero_req && zero_open_cmd_i;
      zero_short_start_o <= zero_req && !zero_open_cmd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and service request
  logic request_service_flag, next_request_service_flag;
  logic err, zend, next_err, next_zend, srq_event;

  // Poll clears only while a request is pending
  assign status_read = (condition_query_i && is_remote) ||
    (serial_poll_i && request_service_flag);
  assign srq_event = srq_en && ((meas_done_i && trig_wait) || zero_done_i);

  always_comb begin
    next_request_service_flag = request_service_flag;
    next_err = err;
    next_zend = zend;
    if (dev_clear || status_read) begin
      next_request_service_flag = 1'b0;
      next_err = 1'b0;
      next_zend = 1'b0;
    end
    if (zero_req) next_zend = 1'b0;
    if (zero_done_i && !zero_fail_i) next_err = 1'b0;
    // Events win over a clear in the same cycle
    if (srq_event) next_request_service_flag = 1'b1;
    if (zero_done_i && zero_fail_i) next_err = 1'b1;
    if (zero_done_i) next_zend = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      request_service_flag <= RST_FLAG;
      err <= RST_FLAG;
      zend <= RST_FLAG;
    end else begin
      request_service_flag <= next_request_service_flag;
      err <= next_err;
      zend <= next_zend;
    end
  end

  always_comb begin
    status_byte_o = '0;
    status_byte_o[STAT_REQ_SVC_BIT] = request_service_flag;
    status_byte_o[STAT_ERR_BIT] = err;
    status_byte_o[STAT_BUSY_BIT] = busy;
    status_byte_o[STAT_ZERO_BIT] = zend;
  end

  assign srq_o = request_service_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_clear;
    dev_clear && !srq_event;
  endsequence

  sequence s_trig_then_get;
    trig_req ##1 (get_i && meas_run && !meas_done_i);
  endsequence

  chk_ifc_drops_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ifc_i |=> !listener && !talker) else $error("addressing kept after IFC");

  chk_clear_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_clear |=> !srq_o && !srq_en && !hdr_en) else $error("clear left SRQ or enables");

  chk_clear_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dev_clear && !trig_req |=> !trig_wait) else $error("trigger wait survived clear");

  chk_get_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_trig_then_get |-> !trig_req) else $error("second trigger taken while busy");

  chk_local_get: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !is_remote |-> !trig_req ##1 !meas_start_o) else $error("trigger taken in local");

  chk_go_remote: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ren_i && my_listen_addr_i |=> remote_o) else $error("remote not entered");

  chk_go_local: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ren_i |=> !remote_o) else $error("remote kept with REN false");

  chk_keys: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    is_remote && !key_is_err_reset_i |-> !key_accept_o) else $error("key passed in remote");

  chk_srq_raise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    srq_en && zero_done_i |=> srq_o && status_byte_o[STAT_ZERO_BIT])
    else $error("SRQ not raised on zero end");

  chk_poll_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    serial_poll_i && !request_service_flag && !condition_query_i && !dev_clear &&
    !zero_done_i && !zero_req
    |=> $stable(err) && $stable(zend)) else $error("idle poll changed status");

  chk_fixed_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_byte_o[7] == 1'b0 && status_byte_o[2:0] == 3'h0) else $error("fixed bits set");

  chk_busy_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    trig_req |=> status_byte_o[STAT_BUSY_BIT]) else $error("busy bit not shown");

endmodule : gpib_remote_status_control
`default_nettype wire

// ==== gpib_rsc_pkg.sv ====
// Constants for the bus remote, status and service request control block
`default_nettype none
package gpib_rsc_pkg;
  // Status word field positions
  localparam int unsigned STAT_W = 8;
  localparam int unsigned STAT_REQ_SVC_BIT = 6;
  localparam int unsigned STAT_ERR_BIT = 5;
  localparam int unsigned STAT_BUSY_BIT = 4;
  localparam int unsigned STAT_ZERO_BIT = 3;
  // Reset values
  localparam logic RST_SRQ_EN = 1'b0;
  localparam logic RST_HDR_EN = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  // Value written by a device clear into the enable settings
  localparam logic CLR_ENABLE_VAL = 1'b0;

  typedef enum logic [1:0] {
    MODE_LOCAL = 2'b01,
    MODE_REMOTE = 2'b10
  } rl_mode_t;
endpackage : gpib_rsc_pkg
`default_nettype wire

// ==== gpib_ctrl_model.sv ====
// Bus controller model: interface messages, addressing and enable codes
`timescale 1ns/1ps
`default_nettype none
module gpib_ctrl_model (
  output logic ifc_o, // Interface clear
  output logic mla_o, // Own listen address
  output logic mta_o, // Own talk address
  output logic unl_o, // Unlisten
  output logic unt_o, // Untalk
  output logic dcl_o, // Universal clear
  output logic sdc_o, // Selective clear
  output logic gtl_o, // Go to local
  output logic get_o, // Group trigger
  output logic spoll_o, // Serial poll sent
  output logic srew_o, // Service request enable code
  output logic srev_o, // Its value
  output logic ren_o // Remote enable level
);
  logic [12:0] m = 13'h0;
  // Each message line keeps the value put on it until the next put
  task put(input int k, input logic v);
    m[k] = v;
  endtask : put
  // Enable value 0 inhibits, 1 admits
  assign {ren_o, srev_o, srew_o, spoll_o, get_o, gtl_o, sdc_o, dcl_o, unt_o, unl_o, mta_o, mla_o,
    ifc_o} = m;
endmodule : gpib_ctrl_model
`default_nettype wire

// ==== gpib_remote_status_control_bench.sv ====
// Self-checking bench for the remote, status and service request control
`timescale 1ns/1ps
`default_nettype none
module gpib_remote_status_control_bench;
  import gpib_rsc_pkg::*;
  localparam int IFC = 0, MLA = 1, MTA = 2, UNL = 3, DCL = 5, SDC = 6, GTL = 7, GET = 8;
  localparam int POLL = 9, SREW = 10, SREV = 11, REN = 12;
  logic clk_i = 1'b0, rst_n_i = 1'b0, header_wr_i = 1'b0, header_val_i = 1'b0;
  logic trigger_cmd_i = 1'b0, zero_open_cmd_i = 1'b0, zero_short_cmd_i = 1'b0;
  logic condition_query_i = 1'b0, meas_done_i = 1'b0, zero_done_i = 1'b0, zero_fail_i = 1'b0;
  logic key_i = 1'b0, key_is_err_reset_i = 1'b0;
  logic ifc_i, ren_i, my_listen_addr_i, my_talk_addr_i, unlisten_i, untalk_i, dcl_i, sdc_i;
  logic gtl_i, get_i, serial_poll_i, srq_enable_wr_i, srq_enable_val_i;
  logic srq_o, remote_o, listener_o, talker_o, srq_enable_o, header_enable_o, meas_start_o;
  logic zero_open_start_o, zero_short_start_o, clear_error_o, flush_tx_o, flush_rx_o;
  logic setup_exit_o, key_accept_o, bus_codes_enable_o;
  logic [STAT_W-1:0] status_byte_o;
  int n_mismatch = 0;
  int samples_checked = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t output differs", $time); end end
`define P(s) begin s = 1'b1; @(negedge clk_i); s = 1'b0; end
`define PC(s, o, v) begin s = 1'b1; #1 `CHK(o, v) @(negedge clk_i); s = 1'b0; end
`define M(k) begin i_ctrl.put(k, 1'b1); @(negedge clk_i); i_ctrl.put(k, 1'b0); end
`define MC(k, o, v) begin i_ctrl.put(k, 1'b1); #1 `CHK(o, v) @(negedge clk_i); \
  i_ctrl.put(k, 1'b0); end
  always #2 clk_i = ~clk_i;
  gpib_remote_status_control i_gpib_remote_status_control (.clk_i, .rst_n_i, .ifc_i, .ren_i,
    .my_listen_addr_i, .my_talk_addr_i, .unlisten_i, .untalk_i, .dcl_i, .sdc_i, .gtl_i, .get_i,
    .srq_enable_wr_i, .srq_enable_val_i, .header_wr_i, .header_val_i, .trigger_cmd_i,
    .zero_open_cmd_i, .zero_short_cmd_i, .condition_query_i, .serial_poll_i, .meas_done_i,
    .zero_done_i, .zero_fail_i, .key_i, .key_is_err_reset_i, .srq_o, .status_byte_o, .remote_o,
    .listener_o, .talker_o, .srq_enable_o, .header_enable_o, .meas_start_o, .zero_open_start_o,
    .zero_short_start_o, .clear_error_o, .flush_tx_o, .flush_rx_o, .setup_exit_o, .key_accept_o,
    .bus_codes_enable_o);
  gpib_ctrl_model i_ctrl (.ifc_o(ifc_i), .mla_o(my_listen_addr_i), .mta_o(my_talk_addr_i),
    .unl_o(unlisten_i), .unt_o(untalk_i), .dcl_o(dcl_i), .sdc_o(sdc_i), .gtl_o(gtl_i),
    .get_o(get_i), .spoll_o(serial_poll_i), .srew_o(srq_enable_wr_i),
    .srev_o(srq_enable_val_i), .ren_o(ren_i));
  task final_report;
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK({remote_o, status_byte_o}, 9'h000);
    i_ctrl.put(REN, 1'b1);
    `MC(MLA, setup_exit_o, 1'b1);
    `CHK({remote_o, listener_o, bus_codes_enable_o}, 3'b111);
    // Zero correction with service requests inhibited
    `P(zero_open_cmd_i);
    `CHK({zero_open_start_o, status_byte_o}, {1'b1, 8'h10});
    zero_fail_i = 1'b1;
    `P(zero_done_i);
    zero_fail_i = 1'b0;
    `CHK({srq_o, status_byte_o}, {1'b0, 8'h28});
    `M(POLL);
    `CHK(status_byte_o, 8'h28);
    `P(zero_short_cmd_i);
    `CHK({zero_short_start_o, status_byte_o}, {1'b1, 8'h30});
    `P(zero_done_i);
    `CHK(status_byte_o, 8'h08);
    `P(condition_query_i);
    `CHK(status_byte_o, 8'h00);
    // Triggered measurement with service requests admitted
    i_ctrl.put(SREV, 1'b1);
    `M(SREW);
    `CHK(srq_enable_o, 1'b1);
    header_val_i = 1'b1;
    `P(header_wr_i);
    `CHK(header_enable_o, 1'b1);
    `P(trigger_cmd_i);
    `CHK({meas_start_o, status_byte_o}, {1'b1, 8'h10});
    `M(GET);
    `CHK(meas_start_o, 1'b0);
    `P(meas_done_i);
    `CHK({srq_o, status_byte_o}, {1'b1, 8'h40});
    `M(POLL);
    `CHK({srq_o, status_byte_o}, 9'h000);
    `P(zero_open_cmd_i);
    `P(zero_done_i);
    `CHK({srq_o, status_byte_o}, {1'b1, 8'h48});
    `MC(SDC, {clear_error_o, flush_tx_o, flush_rx_o}, 3'b111);
    `CHK({srq_o, status_byte_o, srq_enable_o, header_enable_o}, 11'h000);
    // Clear cancels the end-of-measurement wait
    `M(SREW);
    `M(GET);
    `CHK(meas_start_o, 1'b1);
    `MC(DCL, flush_tx_o, 1'b1);
    `M(SREW);
    `P(meas_done_i);
    `CHK({srq_o, status_byte_o}, 9'h000);
    `PC(key_i, key_accept_o, 1'b0);
    key_is_err_reset_i = 1'b1;
    @(negedge clk_i);
    `PC(key_i, key_accept_o, 1'b1);
    key_is_err_reset_i = 1'b0;
    `M(UNL);
    `MC(SDC, flush_tx_o, 1'b0);
    `M(GTL);
    `CHK({listener_o, remote_o}, 2'b01);
    `M(GET);
    `CHK(meas_start_o, 1'b0);
    `M(MLA);
    `P(trigger_cmd_i);
    `M(GTL);
    `CHK({remote_o, bus_codes_enable_o, status_byte_o[STAT_BUSY_BIT]}, 3'b001);
    `P(meas_done_i);
    `M(GET);
    `CHK(meas_start_o, 1'b0);
    `P(condition_query_i);
    `CHK({srq_o, status_byte_o}, {1'b1, 8'h40});
    `MC(DCL, flush_rx_o, 1'b1);
    `CHK(srq_o, 1'b0);
    `M(SREW);
    `CHK(srq_enable_o, 1'b0);
    `PC(key_i, key_accept_o, 1'b1);
    `M(MLA);
    i_ctrl.put(REN, 1'b0);
    @(negedge clk_i);
    `CHK(remote_o, 1'b0);
    `M(MTA);
    `CHK({talker_o, listener_o}, 2'b10);
    `M(IFC);
    `CHK({talker_o, listener_o}, 2'b00);
    final_report;
  end
endmodule : gpib_remote_status_control_bench
`default_nettype wire
